// >>> design/pms_core.sv
// Purpose: power mode state machine of the sequencer
// Assumes: wake inputs already synchronised, requests are pulses
// Notes: instruction completion is signalled by instr_done
`timescale 1ns/100ps
`default_nettype none
module pms_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests
  pms_req_if.dst req,
  // events
  input wire logic instr_done,
  input wire logic irq_pend,
  input wire logic port_match,
  input wire logic cmp_low,
  input wire logic wdt_expire,
  input wire logic mcd_fault,
  // state
  output pms_pkg::pms_mode_t mode_q,
  output logic wake_pulse_q,
  output logic int_reset_q
);
  pms_pkg::pms_mode_t mode_d;
  logic pend_idle_q;
  logic pend_stop_q;
  logic pend_susp_q;
  logic idle_wake;
  logic susp_wake;
  logic wdt_rst;
  logic mcd_rst;

  // wake and termination events per mode
  assign idle_wake = (mode_q == pms_pkg::PMS_IDLE) && irq_pend;
  assign wdt_rst = (mode_q != pms_pkg::PMS_STOP) && req.wdt_en && wdt_expire;
  assign mcd_rst = req.mcd_en && mcd_fault;
  assign susp_wake = (mode_q == pms_pkg::PMS_SUSPEND) &&
    (port_match || (req.cmp_wake_en && cmp_low));

  // next mode; stop ends only by reset
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      pms_pkg::PMS_RUN: begin
        if (instr_done) begin
          if (pend_stop_q || req.stop_req) begin
            mode_d = pms_pkg::PMS_STOP;
          end else if (pend_idle_q || req.idle_req) begin
            mode_d = pms_pkg::PMS_IDLE;
          end else if (pend_susp_q || req.susp_req) begin
            mode_d = pms_pkg::PMS_SUSPEND;
          end
        end
      end
      pms_pkg::PMS_IDLE: begin
        if (idle_wake) begin
          mode_d = pms_pkg::PMS_RUN;
        end
      end
      pms_pkg::PMS_STOP: begin
        mode_d = pms_pkg::PMS_STOP;
      end
      pms_pkg::PMS_SUSPEND: begin
        if (susp_wake) begin
          mode_d = pms_pkg::PMS_RUN;
        end
      end
      default: begin
        mode_d = pms_pkg::PMS_RUN;
      end
    endcase
  end

  // mode register and pending requests; internal reset returns to run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= pms_pkg::PMS_RUN;
      pend_idle_q <= 1'b0;
      pend_stop_q <= 1'b0;
      pend_susp_q <= 1'b0;
      wake_pulse_q <= 1'b0;
      int_reset_q <= 1'b0;
    end else begin
      int_reset_q <= wdt_rst || mcd_rst;
      wake_pulse_q <= idle_wake || susp_wake;
      if (wdt_rst || mcd_rst) begin
        mode_q <= pms_pkg::PMS_RUN;
        pend_idle_q <= 1'b0;
        pend_stop_q <= 1'b0;
        pend_susp_q <= 1'b0;
      end else begin
        mode_q <= mode_d;
        if (mode_q == pms_pkg::PMS_RUN && instr_done) begin
          pend_idle_q <= 1'b0;
          pend_stop_q <= 1'b0;
          pend_susp_q <= 1'b0;
        end else begin
          pend_idle_q <= pend_idle_q || req.idle_req;
          pend_stop_q <= pend_stop_q || req.stop_req;
          pend_susp_q <= pend_susp_q || req.susp_req;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> design/pms_pkg.sv
// Purpose: shared constants and types of the power mode sequencer
// Assumes: 32-bit APB register access, word-aligned offsets
// Notes: offsets are byte addresses
package pms_pkg;
  // register byte offsets
  localparam logic [7:0] PWR_CTRL_OFF = 8'h00; // power_control_reg
  localparam logic [7:0] OSC_CTRL_OFF = 8'h04; // internal_osc_control_reg
  localparam logic [7:0] WAKE_CFG_OFF = 8'h08;
  localparam logic [7:0] STATUS_OFF = 8'h0c;
  // power_control_reg fields
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int GPF_LSB = 2;
  localparam int GPF_W = 6;
  // internal_osc_control_reg fields
  localparam int SUSPEND_BIT = 5;
  localparam logic [7:0] OSC_CTRL_RST = 8'h00;
  // wake config fields
  localparam int CMP_WAKE_EN_BIT = 0;
  localparam int MCD_EN_BIT = 1;
  localparam int WDT_EN_BIT = 2;
  localparam logic [7:0] WAKE_CFG_RST = 8'h04; // watchdog enabled after reset
  localparam logic [7:0] PWR_CTRL_RST = 8'h00;
  // reset vector
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // power modes
  typedef enum logic [1:0] {
    PMS_RUN,
    PMS_IDLE,
    PMS_STOP,
    PMS_SUSPEND
  } pms_mode_t;
endpackage

// >>> design/pms_req_if.sv
// Purpose: mode request bundle from register file to sequencer core
// Assumes: single clock domain
// Notes: requests are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface pms_req_if;
  logic idle_req;
  logic stop_req;
  logic susp_req;
  logic cmp_wake_en;
  logic mcd_en;
  logic wdt_en;
  modport src (output idle_req, output stop_req, output susp_req,
    output cmp_wake_en, output mcd_en, output wdt_en);
  modport dst (input idle_req, input stop_req, input susp_req,
    input cmp_wake_en, input mcd_en, input wdt_en);
endinterface
`default_nettype wire

// >>> design/pms_top.sv
// Purpose: power mode sequencer with APB register access
// Assumes: 100 MHz ref_clk; wake and fault inputs come from other domains
// Notes: idle and stop select bits read back as zero
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pms_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side
  input wire logic instr_done,
  input wire logic irq_pend,
  output logic cpu_halt,
  output logic cpu_wake,
  output logic cpu_reset_req,
  output logic [15:0] fetch_vector,
  // clock gates
  output logic int_osc_en,
  output logic periph_clk_en,
  output logic ext_osc_hold,
  output logic mcd_run,
  output logic wdt_run,
  // wake and fault sources from other domains
  input wire logic port_match,
  input wire logic cmp_low,
  input wire logic wdt_expire,
  input wire logic mcd_fault
);
  logic rst_s1_q;
  logic rst_sync_n;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [pms_pkg::GPF_W-1:0] gpf_q;
  logic [7:0] osc_ctrl_q;
  logic [7:0] wake_cfg_q;
  logic idle_req_q;
  logic stop_req_q;
  logic susp_req_q;
  pms_pkg::pms_mode_t mode;
  logic wake_pulse;
  logic int_reset;
  logic wr_en;
  logic rd_en;
  logic hit_pwr;
  logic hit_osc;
  logic hit_wcfg;
  logic hit_stat;
  logic mapped;
  logic [31:0] rd_mux;
  logic [7:0] pwr_rd;
  pms_req_if req_bus ();

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // two-flop synchronisers for outside events
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {mcd_fault, wdt_expire, cmp_low, port_match};
      sync2_q <= sync1_q;
    end
  end

  // apb decode
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign hit_pwr = paddr == pms_pkg::PWR_CTRL_OFF;
  assign hit_osc = paddr == pms_pkg::OSC_CTRL_OFF;
  assign hit_wcfg = paddr == pms_pkg::WAKE_CFG_OFF;
  assign hit_stat = paddr == pms_pkg::STATUS_OFF;
  assign mapped = hit_pwr || hit_osc || hit_wcfg || hit_stat;
  assign pwr_rd = {gpf_q, 2'b00};
  assign rd_mux = hit_pwr ? {24'h000000, pwr_rd} :
    hit_osc ? {24'h000000, osc_ctrl_q} :
    hit_wcfg ? {24'h000000, wake_cfg_q} :
    hit_stat ? {30'h00000000, mode} : 32'h00000000;

  // registers; select bits are write-to-act pulses
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gpf_q <= pms_pkg::PWR_CTRL_RST[7:2];
      osc_ctrl_q <= pms_pkg::OSC_CTRL_RST;
      wake_cfg_q <= pms_pkg::WAKE_CFG_RST;
      idle_req_q <= 1'b0;
      stop_req_q <= 1'b0;
      susp_req_q <= 1'b0;
    end else if (int_reset) begin
      gpf_q <= pms_pkg::PWR_CTRL_RST[7:2];
      osc_ctrl_q <= pms_pkg::OSC_CTRL_RST;
      wake_cfg_q <= pms_pkg::WAKE_CFG_RST;
      idle_req_q <= 1'b0;
      stop_req_q <= 1'b0;
      susp_req_q <= 1'b0;
    end else begin
      idle_req_q <= wr_en && hit_pwr && pstrb[0] && pwdata[pms_pkg::IDLE_BIT];
      stop_req_q <= wr_en && hit_pwr && pstrb[0] && pwdata[pms_pkg::STOP_BIT];
      susp_req_q <= wr_en && hit_osc && pstrb[0] && pwdata[pms_pkg::SUSPEND_BIT];
      if (wr_en && hit_pwr && pstrb[0]) begin
        gpf_q <= pwdata[7:2];
      end
      if (wr_en && hit_osc && pstrb[0]) begin
        osc_ctrl_q <= pwdata[7:0] & ~(8'h01 << pms_pkg::SUSPEND_BIT);
      end else if (wake_pulse) begin
        osc_ctrl_q <= osc_ctrl_q; // suspend flag never stored
      end
      if (wr_en && hit_wcfg && pstrb[0]) begin
        wake_cfg_q <= pwdata[7:0];
      end
    end
  end

  // request bundle to core
  assign req_bus.idle_req = idle_req_q;
  assign req_bus.stop_req = stop_req_q;
  assign req_bus.susp_req = susp_req_q;
  assign req_bus.cmp_wake_en = wake_cfg_q[pms_pkg::CMP_WAKE_EN_BIT];
  assign req_bus.mcd_en = wake_cfg_q[pms_pkg::MCD_EN_BIT];
  assign req_bus.wdt_en = wake_cfg_q[pms_pkg::WDT_EN_BIT];

  pms_core u_core (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .req(req_bus.dst),
    .instr_done(instr_done),
    .irq_pend(irq_pend),
    .port_match(sync2_q[0]),
    .cmp_low(sync2_q[1]),
    .wdt_expire(sync2_q[2]),
    .mcd_fault(sync2_q[3]),
    .mode_q(mode),
    .wake_pulse_q(wake_pulse),
    .int_reset_q(int_reset)
  );

  // apb outputs: zero wait state, error on unmapped address
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // power gates and cpu control from mode, wake and reset pulses and wake config
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cpu_halt <= 1'b0;
      cpu_wake <= 1'b0;
      cpu_reset_req <= 1'b0;
      fetch_vector <= pms_pkg::RESET_VECTOR;
      int_osc_en <= 1'b1;
      periph_clk_en <= 1'b1;
      ext_osc_hold <= 1'b1;
      mcd_run <= 1'b0;
      wdt_run <= 1'b0;
    end else begin
      cpu_halt <= mode != pms_pkg::PMS_RUN;
      cpu_wake <= wake_pulse;
      cpu_reset_req <= int_reset;
      fetch_vector <= pms_pkg::RESET_VECTOR;
      int_osc_en <= mode == pms_pkg::PMS_RUN || mode == pms_pkg::PMS_IDLE;
      periph_clk_en <= mode == pms_pkg::PMS_RUN || mode == pms_pkg::PMS_IDLE;
      ext_osc_hold <= 1'b1;
      mcd_run <= req_bus.mcd_en;
      wdt_run <= req_bus.wdt_en && mode != pms_pkg::PMS_STOP;
    end
  end
endmodule
`default_nettype wire

// >>> tb/pms_cpu_model.sv
// Purpose: behavioural core and interrupt logic beside the sequencer
// Assumes: retires instructions only while not halted
// Notes: slow stretches instructions to five cycles
`timescale 1ns/100ps
`default_nettype none
module pms_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench control
  input wire logic slow,
  input wire logic irq_cmd,
  // sequencer side
  input wire logic cpu_halt,
  input wire logic cpu_wake,
  input wire logic cpu_reset_req,
  output logic instr_done,
  output logic irq_pend
);
  logic [2:0] cnt_q;
  logic [2:0] last;
  assign last = slow ? 3'h4 : 3'h1;
  // instruction counter, held at zero while halted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 3'h0;
    else if (cpu_halt || cnt_q == last) cnt_q <= 3'h0;
    else cnt_q <= cnt_q + 3'h1;
  end
  // every instruction is multi-byte, so wake never stalls
  assign instr_done = !cpu_halt && cnt_q == last;
  // pending interrupt held until a wake serves it or a reset drops it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) irq_pend <= 1'b0;
    else if (cpu_wake || cpu_reset_req) irq_pend <= 1'b0;
    else if (irq_cmd) irq_pend <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> tb/pms_top_monitor.sv
// Purpose: port checker of the power mode sequencer
// Assumes: bound to pms_top, one clock domain
// Notes: mode is read from the clock gates
`timescale 1ns/100ps
`default_nettype none
module pms_top_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // watched ports
  input wire logic instr_done,
  input wire logic irq_pend,
  input wire logic cpu_halt,
  input wire logic cpu_wake,
  input wire logic cpu_reset_req,
  input wire logic [15:0] fetch_vector,
  input wire logic int_osc_en,
  input wire logic periph_clk_en,
  input wire logic ext_osc_hold,
  input wire logic mcd_run,
  input wire logic wdt_run,
  input wire logic wdt_expire,
  input wire logic mcd_fault
);
  logic [3:0] since_done_q;
  // cycles since the last completed instruction, saturating
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) since_done_q <= 4'hf;
    else if (instr_done) since_done_q <= 4'h0;
    else if (since_done_q != 4'hf) since_done_q <= since_done_q + 4'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_halt_after_done: assert property ($rose(cpu_halt) |-> since_done_q <= 4'h3)
    else $error("halt without a completed instruction");
  a_idle_clocks: assert property (cpu_halt && int_osc_en |-> periph_clk_en)
    else $error("peripheral clock off in idle");
  a_low_gates: assert property (!int_osc_en |-> !periph_clk_en)
    else $error("peripheral clock on with oscillator off");
  a_idle_irq_wake: assert property (cpu_halt && int_osc_en && irq_pend |-> ##[1:4] cpu_wake)
    else $error("interrupt did not wake idle");
  a_wake_resumes: assert property (cpu_wake |-> ##[0:2] !cpu_halt)
    else $error("wake without restart");
  a_vector_zero: assert property (fetch_vector == 16'h0000 && ext_osc_hold)
    else $error("vector or external oscillator wrong");
  a_mcd_reset: assert property ($rose(mcd_fault) && mcd_run |-> ##[1:5] cpu_reset_req)
    else $error("missing clock without reset");
  a_wdt_reset: assert property ($rose(wdt_expire) && wdt_run |-> ##[1:5] cpu_reset_req)
    else $error("watchdog expiry without reset");
endmodule
`default_nettype wire

// >>> tb/pms_top_tb.sv
// Purpose: self-checking bench of the power mode sequencer
// Assumes: APB slave answers within twenty cycles
// Notes: bus answers are taken at the rising edge, levels at the falling edge
`timescale 1ns/100ps
`default_nettype none
module pms_top_tb;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, rerr, instr_done, irq_pend, cpu_halt, cpu_wake, cpu_reset_req;
  logic [15:0] fetch_vector;
  logic int_osc_en, periph_clk_en, ext_osc_hold, mcd_run, wdt_run;
  logic port_match = 0, cmp_low = 0, wdt_expire = 0, mcd_fault = 0, slow = 0, irq_cmd = 0;
  int mismatches = 0, total_checks = 0, wake_cnt = 0, reset_cnt = 0, cyc = 0, w;
  always #5 ref_clk = ~ref_clk;
  pms_top pms_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_done(instr_done), .irq_pend(irq_pend),
    .cpu_halt(cpu_halt), .cpu_wake(cpu_wake), .cpu_reset_req(cpu_reset_req),
    .fetch_vector(fetch_vector), .int_osc_en(int_osc_en), .periph_clk_en(periph_clk_en),
    .ext_osc_hold(ext_osc_hold), .mcd_run(mcd_run), .wdt_run(wdt_run),
    .port_match(port_match), .cmp_low(cmp_low), .wdt_expire(wdt_expire), .mcd_fault(mcd_fault));
  pms_cpu_model pms_cpu_model_i (.clk(ref_clk), .rst_n(rst_n), .slow(slow), .irq_cmd(irq_cmd),
    .cpu_halt(cpu_halt), .cpu_wake(cpu_wake), .cpu_reset_req(cpu_reset_req),
    .instr_done(instr_done), .irq_pend(irq_pend));
  logic reset_prev = 1'b0;
  // count wake pulses and internal reset episodes; a held watchdog expiry keeps the reset up
  always @(posedge ref_clk) begin
    if (cpu_wake === 1'b1) wake_cnt++;
    if (cpu_reset_req === 1'b1 && reset_prev !== 1'b1) reset_cnt++;
    reset_prev = cpu_reset_req;
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    // access held until pready is seen high at a rising edge
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
    chk("pready", pready, 1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", rdat, e);
  endtask
  task automatic halt_is(input logic v);
    int n;
    n = 0;
    do begin @(negedge ref_clk); n++; end while (cpu_halt !== v && n < 40);
    chk("cpu_halt", cpu_halt, v);
    @(posedge ref_clk);
  endtask
  // drive one wake or fault source: 0 port match, 1 comparator, 2 watchdog, 3 clock loss
  task automatic set_src(input logic [1:0] k, input logic v);
    case (k)
      2'h0: port_match <= v;
      2'h1: cmp_low <= v;
      2'h2: wdt_expire <= v;
      default: mcd_fault <= v;
    endcase
  endtask
  task automatic hold_in(input logic [1:0] k);
    set_src(k, 1'b1);
    repeat (5) @(posedge ref_clk);
    set_src(k, 1'b0);
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_regs();
    rd(pms_pkg::WAKE_CFG_OFF, 32'h4);
    rd(pms_pkg::STATUS_OFF, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", rerr, 1);
    $display("regs done");
  endtask
  task automatic t_idle();
    slow <= 1'b1;
    apb(1'b1, pms_pkg::PWR_CTRL_OFF, 32'hfd);
    halt_is(1'b1);
    rd(pms_pkg::STATUS_OFF, 32'h1);
    rd(pms_pkg::PWR_CTRL_OFF, 32'hfc);
    chk("periph_clk_en", periph_clk_en, 1);
    hold_in(2'h0);
    halt_is(1'b1);
    w = wake_cnt;
    irq_cmd <= 1'b1;
    @(posedge ref_clk);
    irq_cmd <= 1'b0;
    halt_is(1'b0);
    repeat (3) @(posedge ref_clk);
    chk("wake", wake_cnt, w + 1);
    rd(pms_pkg::STATUS_OFF, 32'h0);
    $display("idle done");
  endtask
  task automatic t_stop();
    slow <= 1'b0;
    apb(1'b1, pms_pkg::WAKE_CFG_OFF, 32'h6);
    apb(1'b1, pms_pkg::PWR_CTRL_OFF, 32'h3);
    halt_is(1'b1);
    rd(pms_pkg::STATUS_OFF, 32'h2);
    chk("int_osc_en", int_osc_en, 0);
    chk("wdt_run", wdt_run, 0);
    chk("mcd_run", mcd_run, 1);
    chk("periph_clk_en", periph_clk_en, 0);
    irq_cmd <= 1'b1;
    hold_in(2'h0);
    irq_cmd <= 1'b0;
    halt_is(1'b1);
    w = reset_cnt;
    hold_in(2'h3);
    chk("reset", reset_cnt, w + 1);
    halt_is(1'b0);
    rd(pms_pkg::WAKE_CFG_OFF, 32'h4);
    $display("stop done");
  endtask
  task automatic t_susp();
    // firmware is taken to have set zero_tempco_enable before each suspend
    apb(1'b1, pms_pkg::OSC_CTRL_OFF, 32'h20);
    halt_is(1'b1);
    rd(pms_pkg::STATUS_OFF, 32'h3);
    rd(pms_pkg::PWR_CTRL_OFF, 32'h0);
    hold_in(2'h1);
    halt_is(1'b1);
    w = wake_cnt;
    hold_in(2'h0);
    halt_is(1'b0);
    chk("wake", wake_cnt, w + 1);
    apb(1'b1, pms_pkg::WAKE_CFG_OFF, 32'h5);
    apb(1'b1, pms_pkg::OSC_CTRL_OFF, 32'h20);
    halt_is(1'b1);
    hold_in(2'h1);
    halt_is(1'b0);
    $display("suspend done");
  endtask
  task automatic t_wdt();
    apb(1'b1, pms_pkg::PWR_CTRL_OFF, 32'h1);
    halt_is(1'b1);
    w = reset_cnt;
    hold_in(2'h2);
    chk("reset", reset_cnt, w + 1);
    halt_is(1'b0);
    chk("fetch_vector", fetch_vector, pms_pkg::RESET_VECTOR);
    $display("watchdog done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    t_regs();
    t_idle();
    t_stop();
    t_susp();
    t_wdt();
    end_sim();
  end
endmodule
bind pms_top pms_top_monitor pms_top_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .instr_done(instr_done), .irq_pend(irq_pend), .cpu_halt(cpu_halt), .cpu_wake(cpu_wake),
  .cpu_reset_req(cpu_reset_req), .fetch_vector(fetch_vector), .int_osc_en(int_osc_en),
  .periph_clk_en(periph_clk_en), .ext_osc_hold(ext_osc_hold), .mcd_run(mcd_run),
  .wdt_run(wdt_run), .wdt_expire(wdt_expire), .mcd_fault(mcd_fault));
`default_nettype wire
